// ===== design/bsc_ctrl.sv
// Buck regulator control: APB registers, shut-down sequencing, switching frequency and phase timing
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "bsc_defines.svh"

// Summary of operation
// (R1) Setpoint code is volts times 256
// (R2) Hard-disable from pin, command, policy, rail
// (R3) Hard-disable: drivers off, ramp zeroed together
// (R4) Soft-off request waits programmed delay first
// (R5) Ramp down linearly; drivers off at zero
// (R6) Hard shut-down is the reset default
// (R7) Power input rail loss is always hard
// (R8) Pseudo-constant-frequency default; PLL off at reset
// (R9) Default frequency scales with output voltage
// (R10) PLL mode applies after enable pin cycle
// (R11) PLL frequency chosen from setpoint band
// (R12) PLL trims on-time to hold frequency
// (R13) Minimum on-time while output still small
// (R14) Phase high-side pulses never overlap; code overlaps them once half a period is below the minimum on-time
// (R15) Minimum off-time keeps sync switch, samples
// (R16) Default policy follows enable pin level
// (R17) Ramp up only with valid enable
// (R18) Hard-disable overrides any soft-stop phase
module bsc_ctrl (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              enable_pin_i,
  input  wire logic              power_input_rail_low_i,
  input  wire logic              fb_below_i,
  output bsc_pkg::bsc_drv_t      phase0_o,
  output bsc_pkg::bsc_drv_t      phase1_o,
  output logic      [15:0]       ss_ref_o,
  output logic                   pll_active_o
);

  localparam logic [15:0] SHORTEST_ON_PULSE  = 16'(`BSC_SHORTEST_ON_PULSE_CYC);
  localparam logic [15:0] SHORTEST_OFF_PULSE = 16'(`BSC_SHORTEST_OFF_PULSE_CYC);
  localparam logic [15:0] PCF_NUM  = 16'(`BSC_PCF_NUMER);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sy1_q, sy2_q;
  logic       en_s, rail_low_s, fb_below_s;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sy1_q <= 3'h0;
      sy2_q <= 3'h0;
    end else begin
      sy1_q <= {fb_below_i, power_input_rail_low_i, enable_pin_i};
      sy2_q <= sy1_q;
    end
  end

  assign en_s       = sy2_q[0];
  assign rail_low_s = sy2_q[1];
  assign fb_below_s = sy2_q[2];

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [15:0] vout_q,  vout_d;
  logic        op_on_q, op_on_d;
  logic [2:0]  onoff_q, onoff_d;
  logic [15:0] tdly_q,  tdly_d;
  logic [15:0] tfall_q, tfall_d;
  logic [15:0] trise_q, trise_d;
  logic        pll_en_q, pll_en_d;
  logic [7:0]  ton_nom_q, ton_nom_d;
  logic [31:0] rdata_q, rdata_d;
  logic        mapped;
  logic        wr_acc;
  bsc_pkg::bsc_state_t st_q, st_d;
  logic [15:0] ss_q, ss_d;
  logic        pll_act_q, pll_act_d;

  always_comb begin
    mapped = 1'b1;
    rdata_d = rdata_q;
    if (paddr_i == `BSC_OFS_VOUT) begin
      rdata_d = {16'h0000, vout_q};
    end else if (paddr_i == `BSC_OFS_OPER) begin
      rdata_d = {24'h000000, op_on_q, 7'h00};
    end else if (paddr_i == `BSC_OFS_ONOFF) begin
      rdata_d = {29'h00000000, onoff_q};
    end else if (paddr_i == `BSC_OFS_TOFF_DLY) begin
      rdata_d = {16'h0000, tdly_q};
    end else if (paddr_i == `BSC_OFS_TOFF_FALL) begin
      rdata_d = {16'h0000, tfall_q};
    end else if (paddr_i == `BSC_OFS_TON_RISE) begin
      rdata_d = {16'h0000, trise_q};
    end else if (paddr_i == `BSC_OFS_PLL) begin
      rdata_d = {30'h00000000, pll_act_q, pll_en_q};
    end else if (paddr_i == `BSC_OFS_TON_NOM) begin
      rdata_d = {24'h000000, ton_nom_q};
    end else if (paddr_i == `BSC_OFS_STATUS) begin
      rdata_d = {12'h000, 1'b0, st_q, ss_q};
    end else begin
      mapped  = 1'b0;
      rdata_d = 32'h00000000;
    end
    // Read data sampled in the setup cycle so it is a flop output in the access cycle
    if (!(psel_i && !penable_i)) begin
      rdata_d = rdata_q;
    end
  end

  assign wr_acc = psel_i && penable_i && pwrite_i && mapped;

  always_comb begin
    vout_d    = vout_q;
    op_on_d   = op_on_q;
    onoff_d   = onoff_q;
    tdly_d    = tdly_q;
    tfall_d   = tfall_q;
    trise_d   = trise_q;
    pll_en_d  = pll_en_q;
    ton_nom_d = ton_nom_q;
    if (wr_acc) begin
      if (paddr_i == `BSC_OFS_VOUT) begin
        vout_d = pwdata_i[15:0]; // R1
      end else if (paddr_i == `BSC_OFS_OPER) begin
        op_on_d = pwdata_i[`BSC_OPER_ON_BIT];
      end else if (paddr_i == `BSC_OFS_ONOFF) begin
        onoff_d = pwdata_i[2:0];
      end else if (paddr_i == `BSC_OFS_TOFF_DLY) begin
        tdly_d = pwdata_i[15:0];
      end else if (paddr_i == `BSC_OFS_TOFF_FALL) begin
        tfall_d = pwdata_i[15:0];
      end else if (paddr_i == `BSC_OFS_TON_RISE) begin
        trise_d = pwdata_i[15:0];
      end else if (paddr_i == `BSC_OFS_PLL) begin
        pll_en_d = pwdata_i[`BSC_PLL_EN_BIT];
      end else if (paddr_i == `BSC_OFS_TON_NOM) begin
        ton_nom_d = pwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      vout_q    <= `BSC_RST_VOUT;
      op_on_q   <= 1'b1;
      onoff_q   <= `BSC_RST_ONOFF; // R6
      tdly_q    <= `BSC_RST_TOFF_DLY;
      tfall_q   <= `BSC_RST_TOFF_FALL;
      trise_q   <= `BSC_RST_TON_RISE;
      pll_en_q  <= 1'b0; // R8
      ton_nom_q <= `BSC_RST_TON_NOM;
      rdata_q   <= 32'h00000000;
    end else begin
      vout_q    <= vout_d;
      op_on_q   <= op_on_d;
      onoff_q   <= onoff_d;
      tdly_q    <= tdly_d;
      tfall_q   <= tfall_d;
      trise_q   <= trise_d;
      pll_en_q  <= pll_en_d;
      ton_nom_q <= ton_nom_d;
      rdata_q   <= rdata_d;
    end
  end

  assign prdata_o  = rdata_q;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ----------------------------------------------------------------
  // Shut-down and soft-start sequencing
  // ----------------------------------------------------------------
  logic        off_req, soft_en, hard_off;
  logic [15:0] cnt_q, cnt_d;
  logic        en_prev_q;

  // Default policy only watches the pin; the command joins only when configured
  assign off_req  = (onoff_q[`BSC_ONOFF_PIN_BIT] && !en_s)
                 || (onoff_q[`BSC_ONOFF_CMD_BIT] && !op_on_q); // R2 R16
  assign soft_en  = onoff_q[`BSC_ONOFF_SOFT_BIT]; // R6
  assign hard_off = rail_low_s || (off_req && !soft_en); // R2 R7

  always_comb begin
    st_d = st_q;
    ss_d = ss_q;
    cnt_d = cnt_q + 1'b1;
    case (st_q)
      bsc_pkg::BSC_OFF: begin
        ss_d  = 16'h0000;
        cnt_d = 16'h0000;
        if (!off_req && !rail_low_s) begin
          st_d = bsc_pkg::BSC_RISE; // R17
        end
      end
      bsc_pkg::BSC_RISE, bsc_pkg::BSC_ON: begin
        if (off_req) begin
          st_d  = bsc_pkg::BSC_DELAY; // R4
          cnt_d = 16'h0000;
        end else if (ss_q == vout_q) begin
          st_d  = bsc_pkg::BSC_ON;
          cnt_d = 16'h0000;
        end else if (cnt_d >= trise_q) begin
          // Later setpoint changes are tracked at the rise rate in both directions
          ss_d  = (ss_q < vout_q) ? ss_q + 1'b1 : ss_q - 1'b1; // R17
          st_d  = bsc_pkg::BSC_RISE;
          cnt_d = 16'h0000;
        end
      end
      bsc_pkg::BSC_DELAY: begin
        if (!off_req) begin
          st_d  = bsc_pkg::BSC_RISE;
          cnt_d = 16'h0000;
        end else if (cnt_d >= tdly_q) begin
          st_d  = bsc_pkg::BSC_FALL; // R4
          cnt_d = 16'h0000;
        end
      end
      bsc_pkg::BSC_FALL: begin
        if (ss_q == 16'h0000) begin
          st_d = bsc_pkg::BSC_OFF; // R5
        end else if (cnt_d >= tfall_q) begin
          ss_d  = ss_q - 1'b1; // R5
          cnt_d = 16'h0000;
        end
      end
      default: begin
        st_d = bsc_pkg::BSC_OFF;
      end
    endcase
    // A hard-disable overrides every state, soft-stop included
    if (hard_off) begin
      st_d  = bsc_pkg::BSC_OFF; // R3 R18
      ss_d  = 16'h0000; // R3
      cnt_d = 16'h0000;
    end
  end

  // PLL selection only takes effect on a rising edge of the enable pin
  always_comb begin
    pll_act_d = pll_act_q;
    if (en_s && !en_prev_q) begin
      pll_act_d = pll_en_q; // R10
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_q      <= bsc_pkg::BSC_OFF;
      ss_q      <= 16'h0000;
      cnt_q     <= 16'h0000;
      en_prev_q <= 1'b0;
      pll_act_q <= 1'b0; // R8
    end else begin
      st_q      <= st_d;
      ss_q      <= ss_d;
      cnt_q     <= cnt_d;
      en_prev_q <= en_s;
      pll_act_q <= pll_act_d;
    end
  end

  assign ss_ref_o     = ss_q;
  assign pll_active_o = pll_act_q;

  // ----------------------------------------------------------------
  // Switching period and on-time
  // ----------------------------------------------------------------
  logic [15:0] period, half, ton_max, ton_sel, ton_eff;
  logic [15:0] per_q, per_d;
  logic [15:0] ton_pll_q, ton_pll_d;
  logic        run, fire0, fire1;

  always_comb begin
    if (pll_act_q) begin
      if (vout_q < `BSC_CODE_0V65) begin
        period = `BSC_PER_0M50; // R11
      end else if (vout_q <= `BSC_CODE_1V10) begin
        period = `BSC_PER_1M00; // R11
      end else if (vout_q <= `BSC_CODE_1V32) begin
        period = `BSC_PER_1M25; // R11
      end else begin
        period = `BSC_PER_1M50; // R11
      end
    end else begin
      // Divider kept combinational; the setpoint changes rarely so timing is relaxed
      period = PCF_NUM / ((vout_q == 16'h0000) ? 16'h0001 : vout_q); // R9
    end
  end

  assign half    = period >> 1;
  // High-side pulse plus minimum off-time fits in half a period when half exceeds the sum of both minimums, so phases cannot overlap
  assign ton_max = (half > SHORTEST_ON_PULSE + SHORTEST_OFF_PULSE) ? half - SHORTEST_OFF_PULSE : SHORTEST_ON_PULSE; // R14
  assign ton_sel = pll_act_q ? ton_pll_q : {8'h00, ton_nom_q};
  assign ton_eff = (ss_q < `BSC_CODE_STARTUP || ton_sel < SHORTEST_ON_PULSE) ? SHORTEST_ON_PULSE // R13
                 : (ton_sel > ton_max) ? ton_max : ton_sel; // R14
  assign run     = (st_q != bsc_pkg::BSC_OFF) && !hard_off; // R3 R5
  assign fire0   = run && (per_q == 16'h0000);
  assign fire1   = run && (per_q == half); // R14

  always_comb begin
    per_d     = (per_q + 1'b1 >= period || !run) ? 16'h0000 : per_q + 1'b1;
    ton_pll_d = ton_pll_q;
    if (fire0) begin
      // Trim on-time once a period so load changes do not move the frequency
      if (fb_below_s && ton_pll_q < ton_max) begin
        ton_pll_d = ton_pll_q + 1'b1; // R12
      end else if (!fb_below_s && ton_pll_q > SHORTEST_ON_PULSE) begin
        ton_pll_d = ton_pll_q - 1'b1; // R12
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      per_q     <= 16'h0000;
      ton_pll_q <= {8'h00, `BSC_RST_TON_NOM};
    end else begin
      per_q     <= per_d;
      ton_pll_q <= ton_pll_d;
    end
  end

  bsc_phase_leg #(.TW(16)) u_leg0 (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .run_i     (run),
    .fire_i    (fire0),
    .ton_i     (ton_eff),
    .toff_i    (SHORTEST_OFF_PULSE), // R15
    .drv_o     (phase0_o)
  );

  bsc_phase_leg #(.TW(16)) u_leg1 (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .run_i     (run),
    .fire_i    (fire1),
    .ton_i     (ton_eff),
    .toff_i    (SHORTEST_OFF_PULSE), // R15
    .drv_o     (phase1_o)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_hard_off_now: assert property (hard_off |=> ss_q == 16'h0000 && !phase0_o.hi && !phase1_o.hi) // R3
    else $error("hard-disable did not clear ramp and drivers");
  a_rail_is_hard: assert property (rail_low_s && soft_en |=> st_q == bsc_pkg::BSC_OFF) // R7
    else $error("rail loss took the soft path");
  a_soft_overridden: assert property ((st_q == bsc_pkg::BSC_DELAY || st_q == bsc_pkg::BSC_FALL) && rail_low_s
    |=> st_q == bsc_pkg::BSC_OFF && ss_q == 16'h0000) // R18
    else $error("hard-disable did not end soft-stop");
  a_delay_holds: assert property (st_q == bsc_pkg::BSC_DELAY && off_req && !hard_off |=> $stable(ss_q)) // R4
    else $error("ramp moved during off delay");
  a_fall_keeps_run: assert property (st_q == bsc_pkg::BSC_FALL && ss_q != 16'h0000 && !hard_off
    |=> st_q != bsc_pkg::BSC_OFF) // R5
    else $error("drivers disabled before ramp reached zero");
  a_pin_default: assert property (onoff_q == `BSC_RST_ONOFF && !en_s |=> st_q == bsc_pkg::BSC_OFF) // R16
    else $error("default policy ignored enable pin");
  a_no_enable_no_rise: assert property (st_q == bsc_pkg::BSC_OFF && off_req |=> st_q == bsc_pkg::BSC_OFF) // R17
    else $error("ramp started without valid enable");
  a_pll_one_volt: assert property (pll_act_q && vout_q == 16'h0100 |-> period == `BSC_PER_1M00) // R1 R11
    else $error("one volt code gave wrong pll period");
  a_pll_on_cycle: assert property ($rose(pll_act_q) |-> $past(en_s) && !$past(en_prev_q)) // R10
    else $error("pll mode changed without enable cycle");
  a_start_min_on: assert property (ss_q < `BSC_CODE_STARTUP |-> ton_eff == SHORTEST_ON_PULSE) // R13
    else $error("start-up pulse not at minimum on-time");
  a_no_overlap: assert property (!(phase0_o.hi && phase1_o.hi)) // R14
    else $error("high-side pulses overlap");
  a_off_sample: assert property ($fell(phase0_o.hi) && run |-> phase0_o.lo && phase0_o.ocp_sample) // R15
    else $error("sync switch not sampled after high-side pulse");

  c_reach_on: cover property (st_q == bsc_pkg::BSC_ON);
  c_soft_stop: cover property (st_q == bsc_pkg::BSC_FALL ##1 st_q == bsc_pkg::BSC_OFF);
  c_hard_in_fall: cover property (st_q == bsc_pkg::BSC_FALL && rail_low_s);
  c_pll_mode: cover property (pll_act_q && st_q == bsc_pkg::BSC_ON);

endmodule : bsc_ctrl

// ===== design/bsc_defines.svh
// Register offsets, reset values and timing counts for the buck shut-down and frequency control
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BSC_OFS_VOUT       12'h000
`define BSC_OFS_OPER       12'h004
`define BSC_OFS_ONOFF      12'h008
`define BSC_OFS_TOFF_DLY   12'h00c
`define BSC_OFS_TOFF_FALL  12'h010
`define BSC_OFS_TON_RISE   12'h014
`define BSC_OFS_PLL        12'h018
`define BSC_OFS_TON_NOM    12'h01c
`define BSC_OFS_STATUS     12'h020

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BSC_OPER_ON_BIT    7
`define BSC_ONOFF_PIN_BIT  0
`define BSC_ONOFF_CMD_BIT  1
`define BSC_ONOFF_SOFT_BIT 2
`define BSC_PLL_EN_BIT     0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BSC_RST_VOUT       16'h0099
`define BSC_RST_ONOFF      3'h1
`define BSC_RST_TOFF_DLY   16'h0100
`define BSC_RST_TOFF_FALL  16'h0010
`define BSC_RST_TON_RISE   16'h0010
`define BSC_RST_TON_NOM    8'h10

// ----------------------------------------------------------------
// Setpoint codes, 1/256 V per LSB
// ----------------------------------------------------------------
`define BSC_CODE_0V65      16'h00a7
`define BSC_CODE_1V10      16'h011a
`define BSC_CODE_1V32      16'h0152
`define BSC_CODE_STARTUP   16'h0020

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BSC_CLK_KHZ        50000
`define BSC_PCF_BASE_KHZ   470
`define BSC_PCF_BASE_CODE  154
`define BSC_PCF_NUMER      (`BSC_CLK_KHZ * `BSC_PCF_BASE_CODE / `BSC_PCF_BASE_KHZ)
`define BSC_PER_0M50       16'h0064
`define BSC_PER_1M00       16'h0032
`define BSC_PER_1M25       16'h0028
`define BSC_PER_1M50       16'h0021
`define BSC_SHORTEST_ON_PULSE_NS     60
`define BSC_SHORTEST_OFF_PULSE_NS    200
`define BSC_SHORTEST_ON_PULSE_CYC    ((`BSC_SHORTEST_ON_PULSE_NS * `BSC_CLK_KHZ + 999999) / 1000000)
`define BSC_SHORTEST_OFF_PULSE_CYC   ((`BSC_SHORTEST_OFF_PULSE_NS * `BSC_CLK_KHZ + 999999) / 1000000)

`endif

// ===== design/bsc_phase_leg.sv
// One phase leg: on-time pulse, then synchronous switch with over-current sample window
`timescale 1ns/1ns
module bsc_phase_leg #(
  parameter int unsigned TW = 16
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              run_i,
  input  wire logic              fire_i,
  input  wire logic [TW-1:0]     ton_i,
  input  wire logic [TW-1:0]     toff_i,
  output bsc_pkg::bsc_drv_t      drv_o
);

  logic          hi_q,  hi_d;
  logic          lo_q,  lo_d;
  logic          smp_q, smp_d;
  logic [TW-1:0] cnt_q, cnt_d;

  always_comb begin
    hi_d  = hi_q;
    lo_d  = lo_q;
    smp_d = smp_q;
    cnt_d = cnt_q;
    if (!run_i) begin
      hi_d  = 1'b0;
      lo_d  = 1'b0;
      smp_d = 1'b0;
      cnt_d = '0;
    end else if (hi_q) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_d >= ton_i) begin
        hi_d  = 1'b0;
        lo_d  = 1'b1;
        smp_d = 1'b1;
        cnt_d = '0;
      end
    end else if (fire_i && !smp_q) begin
      hi_d  = 1'b1;
      lo_d  = 1'b0;
      cnt_d = '0;
    end else begin
      // Synchronous switch held on for the minimum off-time, current sampled meanwhile
      lo_d = 1'b1;
      if (smp_q) begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_d >= toff_i) begin
          smp_d = 1'b0;
          cnt_d = '0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
      smp_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      hi_q  <= hi_d;
      lo_q  <= lo_d;
      smp_q <= smp_d;
      cnt_q <= cnt_d;
    end
  end

  assign drv_o.hi         = hi_q;
  assign drv_o.lo         = lo_q;
  assign drv_o.ocp_sample = smp_q;

endmodule : bsc_phase_leg

// ===== design/bsc_pkg.sv
// Types shared by the buck shut-down and frequency control
package bsc_pkg;

  typedef enum logic [2:0] {
    BSC_OFF,
    BSC_RISE,
    BSC_ON,
    BSC_DELAY,
    BSC_FALL
  } bsc_state_t;

  typedef struct packed {
    logic hi;
    logic lo;
    logic ocp_sample;
  } bsc_drv_t;

endpackage : bsc_pkg

// ===== sim/bsc_ctrl_bench.sv
// Self-checking bench for the buck shut-down and frequency control
`timescale 1ns/1ns
`include "bsc_defines.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module bsc_ctrl_bench;
  logic sys_clk, reset, psel, penable, pwrite, en_pin, rail_low, fb_below, pready, pslverr, pll_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ss_ref;
  bsc_pkg::bsc_drv_t ph0, ph1;
  int fails, cmp_count, cyc, rise_c, per, wid, overlap, bad_off;
  logic hi_p;

  bsc_ctrl i_bsc_ctrl (.sys_clk_i(sys_clk), .reset_i(reset), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .enable_pin_i(en_pin), .power_input_rail_low_i(rail_low),
    .fb_below_i(fb_below), .phase0_o(ph0), .phase1_o(ph1), .ss_ref_o(ss_ref), .pll_active_o(pll_active));
  bsc_stage_model i_bsc_stage_model (.sys_clk_i(sys_clk), .reset_i(reset), .phase0_i(ph0),
    .phase1_i(ph1), .ss_ref_i(ss_ref), .fb_below_o(fb_below));

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Phase monitor: period, pulse width, overlap, off-interval switch
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      print_verdict();
    end
    if (ph0.hi === 1'b1 && hi_p === 1'b0) begin
      per = cyc - rise_c;
      rise_c = cyc;
    end
    if (ph0.hi === 1'b0 && hi_p === 1'b1) begin
      wid = cyc - rise_c;
      if (ph0.lo !== 1'b1 || ph0.ocp_sample !== 1'b1) bad_off++;
    end
    if (ph0.hi === 1'b1 && ph1.hi === 1'b1) overlap++;
    hi_p = ph0.hi;
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // The master waits for pready for at most 50 cycles
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask : wr

  task automatic wait_st(input logic [2:0] st);
    int n;
    n = 0;
    do begin
      apb(1'b0, `BSC_OFS_STATUS, 32'h0, rd);
      n++;
    end while (rd[18:16] !== st && n < 400);
    `CHK("state", st, rd[18:16])
  endtask : wait_st

  task automatic pin(input logic v);
    @(posedge sys_clk);
    en_pin <= v;
    repeat (5) @(posedge sys_clk);
  endtask : pin

  task automatic t_reset;
    apb(1'b0, `BSC_OFS_ONOFF, 32'h0, rd);
    `CHK("onoff", 32'h1, rd)
    apb(1'b0, `BSC_OFS_PLL, 32'h0, rd);
    `CHK("pll", 32'h0, rd)
    `CHK("pll_active", 1'b0, pll_active)
    apb(1'b0, 12'h040, 32'h0, rd);
    `CHK("unmapped", 1'b1, pslverr)
  endtask : t_reset

  task automatic t_start;
    wr(`BSC_OFS_TON_RISE, 32'h40);
    wr(`BSC_OFS_VOUT, 32'h30);
    pin(1'b1);
    repeat (800) @(posedge sys_clk);
    `CHK("min on", 3, wid)
    `CHK("period", 16391 / 48, per)
    wr(`BSC_OFS_TON_RISE, 32'h1);
    wait_st(3'd2);
    `CHK("ss", 16'h0030, ss_ref)
  endtask : t_start

  task automatic t_hard;
    pin(1'b0);
    `CHK("ss hard", 16'h0, ss_ref)
    `CHK("drv hard", 6'h0, {ph0, ph1})
    pin(1'b1);
    wait_st(3'd2);
    // Command path: policy watches the on bit as well as the pin
    wr(`BSC_OFS_ONOFF, 32'h3);
    wr(`BSC_OFS_OPER, 32'h0);
    apb(1'b0, `BSC_OFS_OPER, 32'h0, rd);
    `CHK("oper", 32'h0, rd)
    repeat (3) @(posedge sys_clk);
    `CHK("ss cmd", 16'h0, ss_ref)
    `CHK("drv cmd", 6'h0, {ph0, ph1})
    wr(`BSC_OFS_OPER, 32'h80);
    wr(`BSC_OFS_ONOFF, 32'h1);
    wait_st(3'd2);
  endtask : t_hard

  task automatic t_rail;
    wr(`BSC_OFS_ONOFF, 32'h5);
    @(posedge sys_clk);
    rail_low <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK("ss rail", 16'h0, ss_ref)
    `CHK("drv rail", 6'h0, {ph0, ph1})
    rail_low <= 1'b0;
    wait_st(3'd2);
  endtask : t_rail

  task automatic t_soft;
    wr(`BSC_OFS_TOFF_DLY, 32'd20);
    wr(`BSC_OFS_TOFF_FALL, 32'd2);
    pin(1'b0);
    `CHK("ss held", 16'h0030, ss_ref)
    wait_st(3'd4);
    while (ss_ref !== 16'h0 && cyc < 59000) begin
      `CHK("drv alive", 1'b1, ph0.hi | ph0.lo)
      @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
    `CHK("drv stop", 6'h0, {ph0, ph1})
    pin(1'b1);
    wait_st(3'd2);
  endtask : t_soft

  task automatic t_abort;
    pin(1'b0);
    rail_low <= 1'b1;
    repeat (5) @(posedge sys_clk);
    `CHK("ss abort", 16'h0, ss_ref)
    `CHK("drv abort", 6'h0, {ph0, ph1})
    rail_low <= 1'b0;
    wr(`BSC_OFS_ONOFF, 32'h1);
    pin(1'b1);
    wait_st(3'd2);
  endtask : t_abort

  task automatic t_pll;
    logic [15:0] codes[4] = '{16'h0080, 16'h0100, 16'h0140, 16'h0160};
    int pers[4] = '{100, 50, 40, 33};
    wr(`BSC_OFS_PLL, 32'h1);
    repeat (10) @(posedge sys_clk);
    `CHK("pll early", 1'b0, pll_active)
    pin(1'b0);
    pin(1'b1);
    `CHK("pll on", 1'b1, pll_active)
    for (int i = 0; i < 4; i++) begin
      wr(`BSC_OFS_VOUT, {16'h0, codes[i]});
      repeat (400) @(posedge sys_clk);
      `CHK("pll period", pers[i], per)
    end
  endtask : t_pll

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    {psel, penable, pwrite, en_pin, rail_low} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    reset = 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_start();
    t_hard();
    t_rail();
    t_soft();
    t_abort();
    t_pll();
    `CHK("overlap", 0, overlap)
    `CHK("off interval", 0, bad_off)
    print_verdict();
  end
endmodule : bsc_ctrl_bench

// ===== sim/bsc_stage_model.sv
// Crude power stage and output filter that closes the loop on the feedback comparator
`timescale 1ns/1ns
module bsc_stage_model (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  bsc_pkg::bsc_drv_t      phase0_i,
  input  bsc_pkg::bsc_drv_t      phase1_i,
  input  wire logic [15:0]       ss_ref_i,
  output logic                   fb_below_o
);
  logic [15:0] vout_q;

  // Output charges while either control switch is on and leaks otherwise
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      vout_q <= 16'h0000;
    end else if (phase0_i.hi || phase1_i.hi) begin
      vout_q <= vout_q + 16'h0002;
    end else if (vout_q != 16'h0000) begin
      vout_q <= vout_q - 16'h0001;
    end
  end

  assign fb_below_o = (vout_q < ss_ref_i);
endmodule : bsc_stage_model
